// ### hw/eitd_pkg.sv
// Package for the external interrupt trigger detect block.
// Assumes an APB master with 32-bit data and word-aligned registers.
package eitd_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_TRIGGER_MODE = 8'h00;
  localparam logic [7:0] OFS_PENDING      = 8'h04;
  localparam logic [7:0] OFS_CLEAR        = 8'h08;
  localparam logic [7:0] OFS_MASK         = 8'h0c;
  localparam logic [7:0] OFS_RAW_PINS     = 8'h10;

  // ****************************************
  // Field codes and reset values
  // ****************************************
  localparam int unsigned FIELD_W = 2;
  localparam logic [1:0] TRIG_LEVEL_HIGH  = 2'h0;
  localparam logic [1:0] TRIG_RISING_EDGE = 2'h2;
  localparam logic [15:0] TRIGGER_MODE_RST = 16'h0000;
  localparam logic [7:0]  MASK_RST         = 8'hff;
  localparam int unsigned MIN_HOLD_CYCLES  = 3;
endpackage

// ### hw/eitd_pin_detect.sv
// One external request pin: level or rising-edge detection into a pending bit.
// Assumes the pin is synchronous to the clock.
`timescale 1ns/1ps
module eitd_pin_detect (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Pin and mode
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  input  wire logic       clear,
  // Result
  output logic            pending
);
  typedef struct packed {
    logic prev;
    logic pend;
  } eitd_pin_state_t;

  eitd_pin_state_t st;
  eitd_pin_state_t next_st;

  always_comb begin
    next_st      = st;
    next_st.prev = pin;
    if (mode == eitd_pkg::TRIG_RISING_EDGE) begin
      // Set wins over clear; repeated edges merge
      if (pin && !st.prev) begin
        next_st.pend = 1'b1;
      end else if (clear) begin
        next_st.pend = 1'b0;
      end
    end else if (mode == eitd_pkg::TRIG_LEVEL_HIGH) begin
      // Level follows the pin each cycle, clear ignored
      next_st.pend = pin;
    end else begin
      // Reserved codes detect nothing
      next_st.pend = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pending = st.pend;
endmodule

// ### hw/eitd_top.sv
// Trigger-mode selection and pending/mask logic for eight external request pins.
// Assumes an APB master on the same clock; inputs synchronous to CLOCK.
// Writes land at the closing edge of the access cycle, reads are taken at setup.
// Reserved trigger codes are stored as written but raise no request.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module eitd_top #(
  parameter int unsigned NUM_PINS = 8
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  // APB slave, request side
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  // APB slave, address and write data
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  // APB slave, answer side
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // External request pins, groups a0..a3 then b0..b3
  input  wire logic [7:0]  EXT_REQ_IN,
  // Masked requests towards the priority logic
  output logic [7:0]       REQ_OUT
);
  // ****************************************
  // Elaboration check
  // ****************************************
  // Field layout and register map are fixed for eight pins
  if (NUM_PINS != 8) begin : g_bad
    $error("eitd_top serves exactly eight pins");
  end
  // Eight fields must fill the 16-bit mode register exactly
  if (eitd_pkg::FIELD_W * NUM_PINS != 16) begin : g_bad_field
    $error("eitd_top needs two-bit trigger fields");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    // Software-visible configuration
    logic [15:0] ext_irq_trigger_mode;
    logic [7:0]  request_mask_reg;
    // Registered APB answer
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // Registered request outputs
    logic [7:0]  req_out;
  } eitd_state_t;

  eitd_state_t st;
  eitd_state_t next_st;

  // ****************************************
  // Local signals
  // ****************************************
  // Detector outputs and clear strobes, one bit per pin
  logic [7:0]  pending_request_reg;
  logic [7:0]  clear_pulse;
  // Bus phase decode
  logic        setup_phase;
  logic        commit_phase;
  logic        wr_commit;
  // Address decode
  logic        sel_trigger_mode;
  logic        sel_pending;
  logic        sel_clear;
  logic        sel_mask;
  logic        sel_raw_pins;
  logic        addr_ok;
  // Read data chosen at setup
  logic [31:0] read_word;

  // ****************************************
  // Per-pin detectors
  // ****************************************
  // Internal sources reach the priority logic elsewhere; only pins pass here
  // Trigger field i sits at bits 2i+1:2i of the mode register
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    eitd_pin_detect u_det (
      .clk     (CLOCK),
      .arst_n  (ARST_N),
      .pin     (EXT_REQ_IN[i]),
      .mode    (st.ext_irq_trigger_mode[eitd_pkg::FIELD_W*i +: eitd_pkg::FIELD_W]),
      .clear   (clear_pulse[i]),
      .pending (pending_request_reg[i])
    );
  end

  // ****************************************
  // Bus phase decode
  // ****************************************
  always_comb begin
    setup_phase  = PSEL && !PENABLE;
    // PREADY stands in this cycle; the write lands at its closing edge
    commit_phase = PSEL && PENABLE && st.pready;
    wr_commit    = commit_phase && PWRITE;
  end

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    // Full-width compare: aliases would hide software errors
    sel_trigger_mode = (PADDR == eitd_pkg::OFS_TRIGGER_MODE);
    sel_pending      = (PADDR == eitd_pkg::OFS_PENDING);
    sel_clear        = (PADDR == eitd_pkg::OFS_CLEAR);
    sel_mask         = (PADDR == eitd_pkg::OFS_MASK);
    sel_raw_pins     = (PADDR == eitd_pkg::OFS_RAW_PINS);
    // Any other address, misaligned ones included, answers with an error
    addr_ok          = sel_trigger_mode || sel_pending || sel_clear || sel_mask || sel_raw_pins;
  end

  // ****************************************
  // Clear strobes
  // ****************************************
  always_comb begin
    clear_pulse = 8'h00;
    // One-cycle strobe; detectors in level mode ignore it
    if (wr_commit && sel_clear) begin
      clear_pulse = PWDATA[7:0];
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    read_word = 32'h0000_0000;
    case (PADDR)
      eitd_pkg::OFS_TRIGGER_MODE: begin
        read_word = {16'h0000, st.ext_irq_trigger_mode};
      end
      eitd_pkg::OFS_PENDING: begin
        read_word = {24'h000000, pending_request_reg};
      end
      eitd_pkg::OFS_MASK: begin
        read_word = {24'h000000, st.request_mask_reg};
      end
      eitd_pkg::OFS_RAW_PINS: begin
        // Pins as they stand now, before any detection
        read_word = {24'h000000, EXT_REQ_IN};
      end
      default: begin
        // Clear register and unmapped addresses read zero
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st         = st;

    // Answer pulse: one access cycle, no wait states
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    if (setup_phase) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !addr_ok;
      // Writes return zero so stale read data never shows
      next_st.prdata  = PWRITE ? 32'h0000_0000 : read_word;
    end

    // Writes to read-only or unmapped offsets are dropped
    if (wr_commit) begin
      case (PADDR)
        eitd_pkg::OFS_TRIGGER_MODE: begin
          next_st.ext_irq_trigger_mode = PWDATA[15:0];
        end
        eitd_pkg::OFS_MASK: begin
          next_st.request_mask_reg = PWDATA[7:0];
        end
        default: begin
        end
      endcase
    end

    // Mask one blocks, zero passes; one cycle behind the pending bits
    next_st.req_out = pending_request_reg & ~st.request_mask_reg;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    // All pins level, all requests blocked until software opens them
    if (!ARST_N) begin
      st                      <= '0;
      st.ext_irq_trigger_mode <= eitd_pkg::TRIGGER_MODE_RST;
      st.request_mask_reg     <= eitd_pkg::MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign PRDATA  = st.prdata;
  assign PREADY  = st.pready;
  assign PSLVERR = st.pslverr;
  assign REQ_OUT = st.req_out;
endmodule

// ### dv/eitd_chk_sva.sv
// Checker for the eitd_top ports: APB answers, clear reads, mask effect.
// Assumes one clock domain; bound to every eitd_top.
`timescale 1ns/1ps
module eitd_chk (
  input wire logic        CLOCK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire logic [7:0]  PADDR, EXT_REQ_IN, REQ_OUT,
  input wire logic [31:0] PWDATA, PRDATA
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  wire st = PSEL && !PENABLE;
  wire wr = st && PWRITE;
  wire rd = st && !PWRITE;
  wire ok = PADDR <= 8'h10 && PADDR[1:0] == 2'h0;
  AST_RDY: assert property (st |=> PREADY) else $error("ready late");
  AST_ERR_WHY: assert property (PSLVERR |-> PREADY && $past(st)) else $error("stray error");
  AST_UNMAP: assert property (st && PADDR > 8'h10 |=> PSLVERR && PRDATA == 32'h0) else $error("unmapped");
  AST_NOERR: assert property (st && ok |=> !PSLVERR) else $error("mapped error");
  AST_CLR_RD: assert property (rd && PADDR == 8'h08 |=> PRDATA == 32'h0) else $error("clear read");
  AST_PEND_W: assert property (rd && PADDR == 8'h04 |=> PRDATA[31:8] == 24'h0) else $error("pend");
  AST_MASK: assert property (wr && PADDR == 8'h0c && PWDATA[7:0] == 8'hff |-> ##3 REQ_OUT == 8'h00)
    else $error("mask");
  AST_QUIET: assert property ($rose(ARST_N) |-> REQ_OUT == 8'h00 && !PREADY) else $error("reset");
  cover property (wr);
  cover property (PSLVERR);
  cover property (REQ_OUT != 8'h00);
endmodule
bind eitd_top eitd_chk eitd_chk_i (.*);

// ### dv/eitd_src_model.sv
// Model of the external request sources on the eight pins.
// Assumes the bench holds each wanted level long enough.
`timescale 1ns/1ps
module eitd_src_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [7:0] want,
  output logic      [7:0] pins = 8'h00
);
  logic [7:0] late = 8'h00;
  // Slow sources answer a cycle late
  always @(posedge clk) begin
    late <= want;
    pins <= slow ? late : want;
  end
endmodule

// ### dv/tb.sv
// Self-checking bench for eitd_top over APB.
// Assumes zero or more wait cycles from the slave.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error %0t: %h not %h", $time, g, e); end end
module tb;
  logic        clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, rerr, pslverr, pready;
  logic [7:0]  paddr = 0, want = 0, pins, req_out;
  logic [31:0] pwdata = 0, prdata, rdat;
  int          error_cnt = 0, num_checks = 0;
  always #4 clock = ~clock;
  eitd_top eitd_top_i (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_REQ_IN(pins), .REQ_OUT(req_out));
  eitd_src_model eitd_src_model_i (.clk(clock), .slow(slow), .want(want), .pins(pins));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CHK(rdat, e)
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    wait_n(12);
    arst_n <= 1;
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'hff);
    rd(8'h14, 32'h0);
    `CHK(rerr, 1'b1)
    apb(1, 8'h0c, 32'h0);
    want <= 8'h01;
    wait_n(4);
    `CHK(req_out, 8'h01)
    apb(1, 8'h08, 32'h01);
    wait_n(2);
    `CHK(req_out, 8'h01)
    rd(8'h04, 32'h01);
    want <= 8'h00;
    wait_n(4);
    rd(8'h04, 32'h00);
    // Pin 1 edge, pin 2 and 3 reserved codes
    slow <= 1;
    apb(1, 8'h00, 32'hd8);
    rd(8'h00, 32'hd8);
    want <= 8'h0e;
    wait_n(eitd_pkg::MIN_HOLD_CYCLES + 2);
    want <= 8'h00;
    wait_n(5);
    rd(8'h04, 32'h02);
    want <= 8'h02;
    wait_n(5);
    rd(8'h08, 32'h0);
    apb(1, 8'h08, 32'h02);
    rd(8'h04, 32'h00);
    want <= 8'h00;
    wait_n(5);
    want <= 8'h02;
    apb(1, 8'h0c, 32'hff);
    wait_n(5);
    `CHK(req_out, 8'h00)
    apb(1, 8'h0c, 32'h00);
    wait_n(3);
    `CHK(req_out, 8'h02)
    rd(8'h0c, 32'h00);
    rd(8'h10, 32'h02);
    final_report;
  end
  initial begin
    wait_n(3000);
    error_cnt++;
    final_report;
  end
endmodule
